/* verilog/adc_general_config_regs.sv */
// General configuration register bank of the sampling converter.
`timescale 1ns/10ps

module adc_general_config_regs (
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register access port from the serial frame decoder.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Device state that steers this bank.
  input wire logic crc_error_in,
  input wire logic cal_done,
  input wire logic [7:0] pin_cfg_in,
  input wire logic [11:0] adc_code,
  input wire logic adc_code_valid,
  // Control outputs to the datapaths.
  output logic rms_module_enable,
  output logic rms_restart,
  output logic crc_enable,
  output logic statistics_enable,
  output logic statistics_clear,
  output logic window_comparator_enable,
  output logic window_comparator_reset,
  output logic force_analog_channels,
  output logic [7:0] channel_is_gpio,
  output logic cal_busy,
  output logic cal_start,
  output logic soft_reset,
  output logic brownout_indicator_set,
  output logic fixed_pattern_output,
  output logic [11:0] read_code,
  output logic append_channel_id,
  output logic append_status_flags,
  output logic [1:0] serial_clock_mode,
  output logic serial_cpol,
  output logic serial_cpha,
  output logic [2:0] averaging_ratio,
  output logic [7:0] average_count,
  output logic continue_on_check_error,
  output logic manual_mode,
  output logic autonomous_mode,
  output logic oscillator_select,
  output logic [3:0] clock_divider
);

  // ------------------------------------------------------------
  // Helper functions.
  // ------------------------------------------------------------

  // Number of samples averaged for a ratio code: code 0 means one.
  function automatic logic [7:0] samples_of(input logic [2:0] code);
    samples_of = 8'h01 << code;
  endfunction : samples_of

  // Address compare used by the decoder and by the checks.
  function automatic logic is_addr(input logic [7:0] a,
                                   input logic [7:0] ofs);
    is_addr = (a == ofs);
  endfunction : is_addr

  // ------------------------------------------------------------
  // Register state.
  // ------------------------------------------------------------
  logic [7:0] gen_r, gen_nxt;       // General configuration.
  logic [7:0] fmt_r, fmt_nxt;       // Data format configuration.
  logic [7:0] avg_r, avg_nxt;       // Averaging configuration.
  logic [7:0] opm_r, opm_nxt;       // Operating mode configuration.
  logic [7:0] rdata_r, rdata_nxt;   // Read data, one cycle after read.
  logic [11:0] code_r, code_nxt;    // Code handed to the serial side.
  logic rms_go_r, rms_go_nxt;       // One-cycle RMS restart.
  logic stat_clr_r, stat_clr_nxt;   // One-cycle statistics clear.
  logic cal_go_r, cal_go_nxt;       // One-cycle calibration start.
  logic swrst_r, swrst_nxt;         // One-cycle reset-done pulse.
  logic wr_ok;                      // A write that is allowed through.
  logic swrst_req;                  // A write of one to the reset bit.

  // ------------------------------------------------------------
  // Write qualification.
  // ------------------------------------------------------------

  // CRC write block
  // Only status and general stay writable after a bad frame, so
  // software can still clear the error and reset the device.
  assign wr_ok = reg_wr && (!crc_error_in ||
                 is_addr(reg_addr, cfg_regs_pkg::OFS_STATUS) ||
                 is_addr(reg_addr, cfg_regs_pkg::OFS_GENERAL));

  assign swrst_req = wr_ok &&
                     is_addr(reg_addr, cfg_regs_pkg::OFS_GENERAL) &&
                     reg_wdata[cfg_regs_pkg::GEN_SWRST];

  // ------------------------------------------------------------
  // Next-state logic of the configuration registers.
  // ------------------------------------------------------------
  always_comb begin
    gen_nxt = gen_r;
    fmt_nxt = fmt_r;
    avg_nxt = avg_r;
    opm_nxt = opm_r;
    if (cal_done) begin
      gen_nxt[cfg_regs_pkg::GEN_CAL] = 1'b0;
    end
    // A write after the clear wins, so a new calibration is not lost.
    if (wr_ok) begin
      unique case (reg_addr)
        cfg_regs_pkg::OFS_GENERAL: begin
          gen_nxt = reg_wdata & cfg_regs_pkg::MASK_GENERAL;
        end
        cfg_regs_pkg::OFS_DATA_FMT: begin
          fmt_nxt = reg_wdata & cfg_regs_pkg::MASK_DATA_FMT;
        end
        cfg_regs_pkg::OFS_AVERAGING: begin
          avg_nxt = reg_wdata & cfg_regs_pkg::MASK_AVERAGING;
        end
        cfg_regs_pkg::OFS_OPMODE: begin
          opm_nxt = reg_wdata & cfg_regs_pkg::MASK_OPMODE;
        end
        default: ; // Other offsets belong to other banks.
      endcase
    end
    // Defaults restored
    // The reset bit overrides every other bit of the same write.
    if (swrst_req) begin
      gen_nxt = cfg_regs_pkg::RST_GENERAL;
      fmt_nxt = cfg_regs_pkg::RST_DATA_FMT;
      avg_nxt = cfg_regs_pkg::RST_AVERAGING;
      opm_nxt = cfg_regs_pkg::RST_OPMODE;
    end
  end

  // Configuration registers.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gen_r <= cfg_regs_pkg::RST_GENERAL;
      fmt_r <= cfg_regs_pkg::RST_DATA_FMT;
      avg_r <= cfg_regs_pkg::RST_AVERAGING;
      opm_r <= cfg_regs_pkg::RST_OPMODE;
    end else begin
      gen_r <= gen_nxt;
      fmt_r <= fmt_nxt;
      avg_r <= avg_nxt;
      opm_r <= opm_nxt;
    end
  end

  // ------------------------------------------------------------
  // Write side effects, registered as one-cycle pulses.
  // ------------------------------------------------------------
  always_comb begin
    rms_go_nxt = wr_ok && !swrst_req &&
                 is_addr(reg_addr, cfg_regs_pkg::OFS_GENERAL) &&
                 reg_wdata[cfg_regs_pkg::GEN_RMS];
    stat_clr_nxt = wr_ok && !swrst_req &&
                   is_addr(reg_addr, cfg_regs_pkg::OFS_GENERAL) &&
                   reg_wdata[cfg_regs_pkg::GEN_STATS];
    cal_go_nxt = wr_ok && !swrst_req &&
                 is_addr(reg_addr, cfg_regs_pkg::OFS_GENERAL) &&
                 reg_wdata[cfg_regs_pkg::GEN_CAL];
    swrst_nxt = swrst_req;
  end

  // Pulse registers.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rms_go_r <= 1'b0;
      stat_clr_r <= 1'b0;
      cal_go_r <= 1'b0;
      swrst_r <= 1'b0;
    end else begin
      rms_go_r <= rms_go_nxt;
      stat_clr_r <= stat_clr_nxt;
      cal_go_r <= cal_go_nxt;
      swrst_r <= swrst_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read data and the code handed to the serial side.
  // ------------------------------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    code_nxt = code_r;
    if (reg_rd) begin
      unique case (reg_addr)
        cfg_regs_pkg::OFS_GENERAL: rdata_nxt = gen_r;
        cfg_regs_pkg::OFS_DATA_FMT: rdata_nxt = fmt_r;
        cfg_regs_pkg::OFS_AVERAGING: rdata_nxt = avg_r;
        cfg_regs_pkg::OFS_OPMODE: rdata_nxt = opm_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    if (adc_code_valid) begin
      code_nxt = fmt_r[cfg_regs_pkg::DAT_FIXED] ?
                 cfg_regs_pkg::FIXED_CODE : adc_code;
    end
  end

  // Read data registers.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
      code_r <= 12'h000;
    end else begin
      rdata_r <= rdata_nxt;
      code_r <= code_nxt;
    end
  end

  // ------------------------------------------------------------
  // Decoded outputs.
  // ------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign read_code = code_r;
  assign rms_module_enable = gen_r[cfg_regs_pkg::GEN_RMS];
  assign rms_restart = rms_go_r;
  assign crc_enable = gen_r[cfg_regs_pkg::GEN_CRC];
  assign statistics_enable = gen_r[cfg_regs_pkg::GEN_STATS];
  assign statistics_clear = stat_clr_r;
  assign window_comparator_enable = gen_r[cfg_regs_pkg::GEN_WCMP];
  assign window_comparator_reset = !gen_r[cfg_regs_pkg::GEN_WCMP];
  // Force analog channels
  // A bad frame with the continue bit set forces them as well.
  assign force_analog_channels = gen_r[cfg_regs_pkg::GEN_FORCE] ||
         (opm_r[cfg_regs_pkg::OPM_CONT] && crc_error_in);
  assign channel_is_gpio = force_analog_channels ? 8'h00 : pin_cfg_in;
  assign cal_busy = gen_r[cfg_regs_pkg::GEN_CAL];
  assign cal_start = cal_go_r;
  assign soft_reset = swrst_r;
  assign brownout_indicator_set = swrst_r;
  assign fixed_pattern_output = fmt_r[cfg_regs_pkg::DAT_FIXED];
  // Append selection
  // The reserved code appends nothing.
  assign append_channel_id =
    (fmt_r[cfg_regs_pkg::DAT_APP_LO +: 2] == cfg_regs_pkg::APP_CHAN_ID);
  assign append_status_flags =
    (fmt_r[cfg_regs_pkg::DAT_APP_LO +: 2] == cfg_regs_pkg::APP_FLAGS);
  assign serial_clock_mode = fmt_r[cfg_regs_pkg::DAT_CLK_LO +: 2];
  assign serial_cpol = serial_clock_mode[1];
  assign serial_cpha = serial_clock_mode[0];
  assign averaging_ratio = avg_r[2:0];
  assign average_count = samples_of(averaging_ratio);
  assign continue_on_check_error = opm_r[cfg_regs_pkg::OPM_CONT];
  // Conversion mode decode
  // Undefined codes fall back to host-started conversions.
  assign autonomous_mode =
    (opm_r[cfg_regs_pkg::OPM_MODE_LO +: 2] == cfg_regs_pkg::MODE_AUTO);
  assign manual_mode = !autonomous_mode;
  assign oscillator_select = opm_r[cfg_regs_pkg::OPM_OSC];
  assign clock_divider = opm_r[cfg_regs_pkg::OPM_DIV_LO +: 4];

  // ------------------------------------------------------------
  // Checks.
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_RMS_RESTART: assert property (
    rms_go_nxt |=> rms_restart && rms_module_enable ##1
    (!rms_restart || $past(rms_go_nxt)))
    else $error("RMS restart not pulsed on enable write.");
  AST_CRC_EN: assert property (
    (wr_ok && !swrst_req && is_addr(reg_addr, cfg_regs_pkg::OFS_GENERAL))
    |=> crc_enable == $past(reg_wdata[cfg_regs_pkg::GEN_CRC]))
    else $error("CRC enable does not follow the write.");
  AST_STATS_CLR: assert property (
    stat_clr_nxt |=> statistics_clear && statistics_enable)
    else $error("Statistics clear missing on enable write.");
  AST_FORCE: assert property (
    gen_r[cfg_regs_pkg::GEN_FORCE] |-> channel_is_gpio == 8'h00)
    else $error("Channel configured as GPIO while forced analog.");
  AST_CAL_CLEAR: assert property (
    (cal_done && !wr_ok) |=> !cal_busy)
    else $error("Calibration bit not cleared on completion.");
  AST_SOFT_RESET: assert property (
    swrst_req |=> (gen_r == 8'h00) && (fmt_r == 8'h00) &&
    (avg_r == 8'h00) && (opm_r == 8'h00))
    else $error("Registers not at defaults after software reset.");
  AST_BROWNOUT: assert property (
    swrst_req |=> brownout_indicator_set ##1
    (!brownout_indicator_set || $past(swrst_req)))
    else $error("Brownout set not a single pulse after reset.");
  AST_RESERVED: assert property (
    (reg_rd && is_addr(reg_addr, cfg_regs_pkg::OFS_DATA_FMT))
    |=> (reg_rdata & 8'h4C) == 8'h00)
    else $error("Reserved data format bits read nonzero.");
  AST_FIXED: assert property (
    (adc_code_valid && fixed_pattern_output) |=> read_code == 12'hA5A)
    else $error("Fixed pattern not returned.");
  AST_AVG: assert property (
    (wr_ok && !swrst_req && is_addr(reg_addr, cfg_regs_pkg::OFS_AVERAGING)
    && reg_wdata[2:0] == 3'h7) |=> average_count == 8'h80)
    else $error("Averaging ratio seven does not give 128.");
  AST_BLOCK: assert property (
    (reg_wr && crc_error_in && is_addr(reg_addr, cfg_regs_pkg::OFS_OPMODE))
    |=> $stable(opm_r))
    else $error("Write went through during a CRC error.");
  AST_RST_READ: assert property (
    (reg_rd && is_addr(reg_addr, cfg_regs_pkg::OFS_GENERAL))
    |=> !reg_rdata[0] && !reg_rdata[3])
    else $error("Write-only or reserved general bit read nonzero.");

endmodule : adc_general_config_regs

/* verilog/cfg_regs_pkg.sv */
// Constants shared by the general configuration register bank.
package cfg_regs_pkg;

  // ------------------------------------------------------------
  // Register offsets on the internal register access port.
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_GENERAL = 8'h01;
  localparam logic [7:0] OFS_DATA_FMT = 8'h02;
  localparam logic [7:0] OFS_AVERAGING = 8'h03;
  localparam logic [7:0] OFS_OPMODE = 8'h04;

  // ------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------
  localparam int GEN_RMS = 7;
  localparam int GEN_CRC = 6;
  localparam int GEN_STATS = 5;
  localparam int GEN_WCMP = 4;
  localparam int GEN_FORCE = 2;
  localparam int GEN_CAL = 1;
  localparam int GEN_SWRST = 0;
  localparam int DAT_FIXED = 7;
  localparam int DAT_APP_LO = 4;
  localparam int DAT_CLK_LO = 0;
  localparam int OPM_CONT = 7;
  localparam int OPM_MODE_LO = 5;
  localparam int OPM_OSC = 4;
  localparam int OPM_DIV_LO = 0;

  // ------------------------------------------------------------
  // Reset values and masks of bits that store a written value.
  // ------------------------------------------------------------
  localparam logic [7:0] RST_GENERAL = 8'h00;
  localparam logic [7:0] RST_DATA_FMT = 8'h00;
  localparam logic [7:0] RST_AVERAGING = 8'h00;
  localparam logic [7:0] RST_OPMODE = 8'h00;
  localparam logic [7:0] MASK_GENERAL = 8'hF6;
  localparam logic [7:0] MASK_DATA_FMT = 8'hB3;
  localparam logic [7:0] MASK_AVERAGING = 8'h07;
  localparam logic [7:0] MASK_OPMODE = 8'hFF;

  // ------------------------------------------------------------
  // Field encodings and the debug pattern.
  // ------------------------------------------------------------
  localparam logic [1:0] APP_NONE = 2'h0;
  localparam logic [1:0] APP_CHAN_ID = 2'h1;
  localparam logic [1:0] APP_FLAGS = 2'h2;
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [11:0] FIXED_CODE = 12'hA5A;

endpackage : cfg_regs_pkg

/* dv/reg_host_model.sv */
// Behavioural host that issues accesses on the register port of the bank.
`timescale 1ns/10ps

module reg_host_model (
  input wire logic sys_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);

  // ----------------------------------------------------------------
  // Idle port state.
  // ----------------------------------------------------------------
  // Strobes start low so that nothing is taken before reset is released.
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One write. The strobe stands for a single taken edge. Address and
  // data are then inverted, so a stale value never passes for a live one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // One read. The data comes back on the edge that drops the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask : rd

endmodule : reg_host_model

/* dv/adc_general_config_regs_tb.sv */
// Self-checking bench for the general configuration register bank.
`timescale 1ns/10ps

module adc_general_config_regs_tb;

  // ----------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------
  logic sys_clk, rst_b, reg_wr, reg_rd, crc_error_in, cal_done;
  logic adc_code_valid, rms_module_enable, rms_restart, crc_enable;
  logic statistics_enable, statistics_clear, window_comparator_enable;
  logic window_comparator_reset, force_analog_channels, cal_busy;
  logic cal_start, soft_reset, brownout_indicator_set;
  logic fixed_pattern_output, append_channel_id, append_status_flags;
  logic serial_cpol, serial_cpha, continue_on_check_error, manual_mode;
  logic autonomous_mode, oscillator_select;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pin_cfg_in, channel_is_gpio;
  logic [7:0] average_count, g;
  logic [11:0] adc_code, read_code, c;
  logic [1:0] serial_clock_mode;
  logic [2:0] averaging_ratio;
  logic [3:0] clock_divider;
  int n_mismatch = 0;
  int tests_run = 0;
  // Expected read data, oldest first; the monitor pops one per read.
  logic [15:0] exp_q[$];
  logic rd_seen = 1'b0;

  adc_general_config_regs adc_general_config_regs_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .crc_error_in(crc_error_in), .cal_done(cal_done),
    .pin_cfg_in(pin_cfg_in), .adc_code(adc_code),
    .adc_code_valid(adc_code_valid), .rms_module_enable(rms_module_enable),
    .rms_restart(rms_restart), .crc_enable(crc_enable),
    .statistics_enable(statistics_enable),
    .statistics_clear(statistics_clear),
    .window_comparator_enable(window_comparator_enable),
    .window_comparator_reset(window_comparator_reset),
    .force_analog_channels(force_analog_channels),
    .channel_is_gpio(channel_is_gpio), .cal_busy(cal_busy),
    .cal_start(cal_start), .soft_reset(soft_reset),
    .brownout_indicator_set(brownout_indicator_set),
    .fixed_pattern_output(fixed_pattern_output), .read_code(read_code),
    .append_channel_id(append_channel_id),
    .append_status_flags(append_status_flags),
    .serial_clock_mode(serial_clock_mode), .serial_cpol(serial_cpol),
    .serial_cpha(serial_cpha), .averaging_ratio(averaging_ratio),
    .average_count(average_count),
    .continue_on_check_error(continue_on_check_error),
    .manual_mode(manual_mode), .autonomous_mode(autonomous_mode),
    .oscillator_select(oscillator_select), .clock_divider(clock_divider));

  reg_host_model reg_host_model_i (.sys_clk(sys_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  // ----------------------------------------------------------------
  // Clock, comparison and closing.
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Case equality, so an unknown never counts as a match.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // Note the expected byte, then read it through the host model.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    reg_host_model_i.rd(a);
  endtask : rchk

  // Settle just after the next edge.
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask : tick

  // Read data is valid the cycle after the strobe is taken; compare it
  // half a cycle later, when every update of that edge has landed.
  always @(posedge sys_clk) rd_seen <= reg_rd;
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) check(16'hFFFF, 16'h0000);
      else check({8'h00, reg_rdata}, exp_q.pop_front());
    end
  end

  // Watchdog: the tests need a few hundred cycles at most.
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    crc_error_in = 1'b0;
    cal_done = 1'b0;
    pin_cfg_in = 8'h00;
    adc_code = 12'h000;
    adc_code_valid = 1'b0;
    void'($urandom(70));
    repeat (5) @(posedge sys_clk);
    // Release away from the edge, as the asynchronous reset expects.
    #1 rst_b = 1'b1;
    check({window_comparator_reset, manual_mode}, 2'b11);
    check(average_count, 8'h01);
    for (int a = 0; a < 6; a++) rchk(a[7:0], 8'h00);
    // 0xFE into 0x01, all ones into 0x02 to 0x05; only storing bits may come back.
    for (int a = 1; a < 6; a++) begin
      reg_host_model_i.wr(a[7:0], (a == 1) ? 8'hFE : 8'hFF);
      rchk(a[7:0], (a == 1) ? 8'hF6 : (a == 2) ? 8'hB3 :
        (a == 3) ? 8'h07 : (a == 4) ? 8'hFF : 8'h00);
    end
    // Software reset with every register holding non-zero values.
    reg_host_model_i.wr(8'h01, 8'h01);
    #1 check({soft_reset, brownout_indicator_set}, 2'b11);
    tick();
    check({soft_reset, brownout_indicator_set}, 2'b00);
    for (int a = 1; a < 5; a++) rchk(a[7:0], 8'h00);
    // One general bit at a time, with a random pin setup underneath.
    @(posedge sys_clk) pin_cfg_in <= 8'($urandom);
    for (int b = 1; b < 8; b++) begin
      g = 8'h01 << b;
      reg_host_model_i.wr(8'h01, g);
      #1 check({rms_module_enable, crc_enable, statistics_enable,
        window_comparator_enable, force_analog_channels, cal_busy},
        {g[7:4], g[2:1]});
      check({rms_restart, statistics_clear, cal_start,
        window_comparator_reset}, {g[7], g[5], g[1], ~g[4]});
      check(channel_is_gpio, g[2] ? 8'h00 : pin_cfg_in);
      tick();
      check({rms_restart, statistics_clear, cal_start}, 3'b000);
    end
    // Calibration finishes and the bit clears itself.
    reg_host_model_i.wr(8'h01, 8'h02);
    @(posedge sys_clk) cal_done <= 1'b1;
    @(posedge sys_clk) cal_done <= 1'b0;
    #1 check(cal_busy, 1'b0);
    rchk(8'h01, 8'h00);
    // Every append code and every clock mode.
    for (int v = 0; v < 4; v++) begin
      reg_host_model_i.wr(8'h02, {2'b00, v[1:0], 2'b00, v[1:0]});
      #1 check({append_channel_id, append_status_flags},
        {v == 1, v == 2});
      check({serial_clock_mode, serial_cpol, serial_cpha},
        {v[1:0], v[1:0]});
    end
    // Conversion results with the debug pattern off, then on.
    for (int f = 0; f < 2; f++) begin
      reg_host_model_i.wr(8'h02, {f[0], 7'h00});
      #1 check(fixed_pattern_output, f[0]);
      c = 12'($urandom);
      @(posedge sys_clk);
      adc_code <= c;
      adc_code_valid <= 1'b1;
      @(posedge sys_clk);
      adc_code_valid <= 1'b0;
      adc_code <= ~c;
      #1 check(read_code, f ? cfg_regs_pkg::FIXED_CODE : c);
    end
    // Every averaging code, and mode codes in the operating register.
    for (int n = 0; n < 8; n++) begin
      reg_host_model_i.wr(8'h03, n[7:0]);
      #1 check(average_count, 8'h01 << n);
      check(averaging_ratio, n[2:0]);
      reg_host_model_i.wr(8'h04, {n[0], n[2:1], n[0], n[3:0]});
      #1 check({autonomous_mode, manual_mode, oscillator_select,
        clock_divider}, {n[2:1] == 1, n[2:1] != 1, n[0], n[3:0]});
      check(continue_on_check_error, n[0]);
    end
    // A pending check error blocks all but offsets 0x00 and 0x01.
    // The continue bit goes in first, so the error also forces analog.
    reg_host_model_i.wr(8'h04, 8'h80);
    reg_host_model_i.wr(8'h03, 8'h02);
    @(posedge sys_clk) crc_error_in <= 1'b1;
    #1 check({force_analog_channels, channel_is_gpio}, 9'h100);
    reg_host_model_i.wr(8'h03, 8'h05);
    rchk(8'h03, 8'h02);
    reg_host_model_i.wr(8'h04, 8'h00);
    rchk(8'h04, 8'h80);
    reg_host_model_i.wr(8'h01, 8'h40);
    rchk(8'h01, 8'h40);
    @(posedge sys_clk) crc_error_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check(force_analog_channels, 1'b0);
    check(exp_q.size(), 16'h0000);
    end_of_test();
  end

endmodule : adc_general_config_regs_tb
